// File: rtl/crf_core_regs.sv
`timescale 1ns/10ps
module crf_core_regs (
    input wire logic CLOCK, // 100 MHz core clock
    input wire logic RST_N, // async reset, active low
    input wire logic [1:0] AMODE, // address mode select
    input wire logic [23:0] RESET_VECTOR, // fetch address loaded on reset
    input wire logic RD_EN, // register read request
    input wire logic [3:0] RA_SEL, // read a view: {upper/high, index}
    input wire logic [3:0] RB_SEL, // read b view
    input wire logic [1:0] RD_SIZE, // read size
    input wire logic WR_EN, // register write
    input wire logic [3:0] WR_SEL, // write view
    input wire logic [1:0] WR_SIZE, // write size
    input wire logic [31:0] WR_DATA, // write data, right aligned
    input wire logic PTR_LOAD, // load fetch pointer
    input wire logic [23:0] PTR_VALUE, // new fetch pointer
    input wire logic PTR_STEP, // advance fetch pointer one word
    input wire logic [23:0] DATA_ADDR, // effective data address
    input wire logic [1:0] DATA_SIZE, // data access size
    input wire logic [2:0] FLAG_OP, // flag operation
    input wire logic [7:0] FLAG_IMM, // immediate for flag ops
    input wire logic [1:0] ALU_SIZE, // arithmetic size
    input wire logic ALU_SUB, // subtract/compare/negate
    input wire logic ALU_ARITH, // half-carry and overflow apply
    input wire logic [31:0] ALU_A, // arithmetic operand a
    input wire logic [31:0] ALU_B, // arithmetic operand b
    input wire logic ALU_CIN, // extend carry in
    input wire logic ALU_ZKEEP, // extend form keeps zero clear
    input wire logic CARRY_SET, // shift/bit op carry update
    input wire logic CARRY_VAL, // shifted-out or accumulator bit
    input wire logic EXC_START, // exception sequence begins
    input wire logic IRQ_REQ, // maskable interrupt pending
    input wire logic NMI_REQ, // non-maskable interrupt pending
    input wire logic [3:0] BR_COND, // branch condition code
    output logic [31:0] RA_DATA, // read a data
    output logic [31:0] RB_DATA, // read b data
    output logic [31:0] STACK_POINTER, // current stack pointer
    output logic [23:0] FETCH_ADDR, // fetch address, even
    output logic [23:0] BUS_ADDR, // data address after width/mode
    output logic [7:0] CONDITION_FLAGS, // flag register
    output logic IRQ_TAKE, // interrupt accepted
    output logic BR_TAKEN // branch condition true
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    crf_pkg::crf_state_t state;
    logic [23:0] next_fetch_pointer;
    logic [7:0] condition_flags;
    logic [31:0] ra_raw, rb_raw, sp_raw;
    logic [3:0] ra_sel_q, rb_sel_q;
    logic [1:0] rd_size_q;

    // ---------------------------------------------------------------
    // write steering into 32-bit entries
    // ---------------------------------------------------------------
    wire wr_long = (WR_SIZE == crf_pkg::SZ_LONG);
    wire wr_word = (WR_SIZE == crf_pkg::SZ_WORD);
    wire wr_up = WR_SEL[3];
    wire [3:0] lane_long = 4'hf; // [RULE1]
    wire [3:0] lane_word = wr_up ? 4'hc : 4'h3; // [RULE2]
    wire [3:0] lane_byte = wr_up ? 4'h2 : 4'h1; // [RULE3]
    wire [3:0] wr_lane = !WR_EN ? 4'h0 : wr_long ? lane_long : wr_word ? lane_word : lane_byte;
    wire [31:0] wr_place = wr_long ? WR_DATA :
                           wr_word ? {WR_DATA[15:0], WR_DATA[15:0]} :
                           {4{WR_DATA[7:0]}};

    crf_regmem #(.DEPTH(8), .WIDTH(32)) u_mem (
        .clk(CLOCK),
        .wr_idx(WR_SEL[2:0]),
        .wr_lane(wr_lane),
        .wr_data(wr_place),
        .ra_idx(RA_SEL[2:0]),
        .rb_idx(RB_SEL[2:0]),
        .ra_data(ra_raw),
        .rb_data(rb_raw),
        .sp_data(sp_raw)
    );

    // ---------------------------------------------------------------
    // read view extraction, applied on the cycle after the request
    // ---------------------------------------------------------------
    function automatic logic [31:0] view(input logic [31:0] r, input logic up, input logic [1:0] sz);
        logic [31:0] v;
        v = r;
        if (sz == crf_pkg::SZ_WORD) begin
            v = {16'h0000, up ? r[31:16] : r[15:0]}; // [RULE2]
        end else if (sz == crf_pkg::SZ_BYTE) begin
            v = {24'h000000, up ? r[15:8] : r[7:0]}; // [RULE3]
        end
        return v;
    endfunction : view

    wire [31:0] ra_view = view(ra_raw, ra_sel_q[3], rd_size_q);
    wire [31:0] rb_view = view(rb_raw, rb_sel_q[3], rd_size_q);

    // ---------------------------------------------------------------
    // arithmetic flag generation
    // ---------------------------------------------------------------
    wire [31:0] b_eff = ALU_SUB ? ~ALU_B : ALU_B;
    wire cin_eff = ALU_SUB ? ~ALU_CIN : ALU_CIN;
    wire [32:0] sum = {1'b0, ALU_A} + {1'b0, b_eff} + {32'h0, cin_eff};
    wire [4:0] lo4 = {1'b0, ALU_A[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_eff};
    wire [12:0] lo12 = {1'b0, ALU_A[11:0]} + {1'b0, b_eff[11:0]} + {12'h0, cin_eff};
    wire [28:0] lo28 = {1'b0, ALU_A[27:0]} + {1'b0, b_eff[27:0]} + {28'h0, cin_eff};
    wire [8:0] lo8 = {1'b0, ALU_A[7:0]} + {1'b0, b_eff[7:0]} + {8'h0, cin_eff};
    wire [16:0] lo16 = {1'b0, ALU_A[15:0]} + {1'b0, b_eff[15:0]} + {16'h0, cin_eff};
    wire s_byte = (ALU_SIZE == crf_pkg::SZ_BYTE);
    wire s_word = (ALU_SIZE == crf_pkg::SZ_WORD);
    // carry out of bit n; a borrow is its inverse on a subtract
    wire c_half = s_byte ? lo4[4] : s_word ? lo12[12] : lo28[28]; // [RULE9] [RULE10] [RULE11]
    wire c_top = s_byte ? lo8[8] : s_word ? lo16[16] : sum[32];
    wire r_msb = s_byte ? sum[7] : s_word ? sum[15] : sum[31];
    wire a_msb = s_byte ? ALU_A[7] : s_word ? ALU_A[15] : ALU_A[31];
    wire b_msb = s_byte ? b_eff[7] : s_word ? b_eff[15] : b_eff[31];
    wire r_zero = s_byte ? (sum[7:0] == 8'h00) : s_word ? (sum[15:0] == 16'h0000) : (sum[31:0] == 32'h0);
    wire f_half = c_half ^ ALU_SUB;
    wire f_carry = c_top ^ ALU_SUB; // [RULE16]
    wire f_ovf = (a_msb == b_msb) && (r_msb != a_msb); // [RULE15]
    wire f_zero = ALU_ZKEEP ? (r_zero & condition_flags[crf_pkg::FLAG_ZERO]) : r_zero; // [RULE14]

    // ---------------------------------------------------------------
    // next flag value; exception entry raises the mask last
    // ---------------------------------------------------------------
    logic [7:0] next_flags;
    always_comb begin
        next_flags = condition_flags;
        case (crf_pkg::crf_flag_op_t'(FLAG_OP))
            crf_pkg::FOP_NONE: next_flags = condition_flags; // [RULE17]
            crf_pkg::FOP_LOAD: next_flags = FLAG_IMM; // [RULE8] [RULE12]
            crf_pkg::FOP_AND: next_flags = condition_flags & FLAG_IMM; // [RULE17]
            crf_pkg::FOP_OR: next_flags = condition_flags | FLAG_IMM;
            crf_pkg::FOP_XOR: next_flags = condition_flags ^ FLAG_IMM;
            crf_pkg::FOP_ALU: begin
                next_flags[crf_pkg::FLAG_NEG] = r_msb; // [RULE13]
                next_flags[crf_pkg::FLAG_ZERO] = f_zero;
                if (ALU_ARITH) begin
                    next_flags[crf_pkg::FLAG_HALF] = f_half; // [RULE9]
                    next_flags[crf_pkg::FLAG_OVF] = f_ovf; // [RULE15]
                    next_flags[crf_pkg::FLAG_CARRY] = f_carry; // [RULE16]
                end else begin
                    next_flags[crf_pkg::FLAG_OVF] = 1'b0;
                end
            end
            default: next_flags = condition_flags;
        endcase
        if (CARRY_SET) begin
            next_flags[crf_pkg::FLAG_CARRY] = CARRY_VAL; // [RULE16]
        end
        if (EXC_START) begin
            next_flags[crf_pkg::FLAG_MASK] = 1'b1; // [RULE7]
        end
    end

    // flags are not written on the vector-load edge, so the output holds too
    wire [7:0] shown_flags = (state == crf_pkg::CST_RUN) ? next_flags : condition_flags;

    // ---------------------------------------------------------------
    // branch conditions on N, Z, V, C
    // ---------------------------------------------------------------
    wire fn = condition_flags[crf_pkg::FLAG_NEG];
    wire fz = condition_flags[crf_pkg::FLAG_ZERO];
    wire fv = condition_flags[crf_pkg::FLAG_OVF];
    wire fc = condition_flags[crf_pkg::FLAG_CARRY];
    logic cond;
    always_comb begin
        case (BR_COND) // [RULE17]
            4'h0: cond = 1'b1;
            4'h1: cond = 1'b0;
            4'h2: cond = !(fc | fz);
            4'h3: cond = fc | fz;
            4'h4: cond = !fc;
            4'h5: cond = fc;
            4'h6: cond = !fz;
            4'h7: cond = fz;
            4'h8: cond = !fv;
            4'h9: cond = fv;
            4'ha: cond = !fn;
            4'hb: cond = fn;
            4'hc: cond = !(fn ^ fv);
            4'hd: cond = fn ^ fv;
            4'he: cond = !(fz | (fn ^ fv));
            4'hf: cond = fz | (fn ^ fv);
            default: cond = 1'b0;
        endcase
    end

    // ---------------------------------------------------------------
    // address forming
    // ---------------------------------------------------------------
    wire [23:0] mode_mask = (AMODE == crf_pkg::AMODE_NORMAL) ? crf_pkg::ADDR_64K_MASK : // [RULE20]
                            (AMODE == crf_pkg::AMODE_1M) ? crf_pkg::ADDR_1M_MASK : 24'hffffff; // [RULE21]
    wire wide_data = (DATA_SIZE != crf_pkg::SZ_BYTE);
    wire [23:0] data_even = {DATA_ADDR[23:1], DATA_ADDR[0] & !wide_data}; // [RULE22]
    wire [23:0] next_bus = data_even & mode_mask;
    wire [23:0] next_fetch = {next_fetch_pointer[23:1], 1'b0} & mode_mask; // [RULE5] [RULE22]
    wire next_irq = NMI_REQ | (IRQ_REQ & !condition_flags[crf_pkg::FLAG_MASK]); // [RULE6]

    // ---------------------------------------------------------------
    // control registers; reset sets only mask, other flags zeroed here
    // ---------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state <= crf_pkg::CST_RESET;
            next_fetch_pointer <= 24'h000000;
            condition_flags <= crf_pkg::FLAGS_RESET; // [RULE18]
        end else begin
            case (state)
                crf_pkg::CST_RESET: begin
                    next_fetch_pointer <= RESET_VECTOR; // [RULE18]
                    state <= crf_pkg::CST_RUN;
                end
                crf_pkg::CST_RUN: begin
                    condition_flags <= next_flags;
                    if (PTR_LOAD) begin
                        next_fetch_pointer <= PTR_VALUE; // [RULE5]
                    end else if (PTR_STEP) begin
                        next_fetch_pointer <= next_fetch_pointer + 24'h000002;
                    end
                end
                default: state <= crf_pkg::CST_RESET;
            endcase
        end
    end

    // registered outputs and read selects
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ra_sel_q <= 4'h0;
            rb_sel_q <= 4'h0;
            rd_size_q <= 2'h0;
            FETCH_ADDR <= 24'h000000;
            BUS_ADDR <= 24'h000000;
            IRQ_TAKE <= 1'b0;
            BR_TAKEN <= 1'b0;
        end else begin
            if (RD_EN) begin
                ra_sel_q <= RA_SEL;
                rb_sel_q <= RB_SEL;
                rd_size_q <= RD_SIZE;
            end
            FETCH_ADDR <= next_fetch;
            BUS_ADDR <= next_bus;
            IRQ_TAKE <= next_irq;
            BR_TAKEN <= cond;
        end
    end

    // view data registered a second time so outputs come from flops
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            RA_DATA <= 32'h0;
            RB_DATA <= 32'h0;
            STACK_POINTER <= 32'h0;
            CONDITION_FLAGS <= crf_pkg::FLAGS_RESET;
        end else begin
            RA_DATA <= ra_view;
            RB_DATA <= rb_view;
            STACK_POINTER <= sp_raw; // [RULE4] [RULE19]
            CONDITION_FLAGS <= shown_flags;
        end
    end
endmodule : crf_core_regs

// File: rtl/crf_pkg.sv
// Notes on behaviour
// [RULE1] eight identical 32-bit registers, any width
// [RULE2] upper and lower 16-bit halves addressable
// [RULE3] lower half splits into two bytes
// [RULE4] eighth register doubles as stack pointer
// [RULE5] 24-bit fetch pointer, bit 0 forced zero
// [RULE6] mask bit blocks all but non-maskable
// [RULE7] exception entry forces mask bit high
// [RULE8] bit 6 user bit, optional mask
// [RULE9] byte arithmetic half-carry at bit 3
// [RULE10] word arithmetic half-carry at bit 11
// [RULE11] longword arithmetic half-carry at bit 27
// [RULE12] bit 4 plain user bit
// [RULE13] negative flag takes result sign bit
// [RULE14] zero flag set on zero result
// [RULE15] overflow flag set on arithmetic overflow
// [RULE16] carry from add, borrow, shift, bit ops
// [RULE17] branch tests, flag ops, flags kept
// [RULE18] reset loads vector, mask set, others undefined
// [RULE19] software loads stack pointer first after reset
// [RULE20] normal 64-kbyte and advanced 16-Mbyte modes
// [RULE21] 1-Mbyte modes drop top four address bits
// [RULE22] odd word accesses start at even address
// [RULE23] narrow writes keep other register bits
package crf_pkg;
    // ---------------------------------------------------------------
    // widths and field positions
    // ---------------------------------------------------------------
    localparam int REG_COUNT = 8;
    localparam int REG_WIDTH = 32;
    localparam int PTR_WIDTH = 24;
    localparam int SP_INDEX = 7;
    localparam int FLAG_MASK = 7;
    localparam int FLAG_USER_MASK = 6;
    localparam int FLAG_HALF = 5;
    localparam int FLAG_USER = 4;
    localparam int FLAG_NEG = 3;
    localparam int FLAG_ZERO = 2;
    localparam int FLAG_OVF = 1;
    localparam int FLAG_CARRY = 0;
    localparam int HALF_BYTE_BIT = 3;
    localparam int HALF_WORD_BIT = 11;
    localparam int HALF_LONG_BIT = 27;
    localparam logic [7:0] FLAGS_RESET = 8'h80;
    localparam logic [23:0] ADDR_1M_MASK = 24'h0fffff;
    localparam logic [23:0] ADDR_64K_MASK = 24'h00ffff;

    // ---------------------------------------------------------------
    // access sizes and selectors
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_WORD = 2'b01,
        SZ_LONG = 2'b10
    } crf_size_t;

    // view select: bit 3 picks upper half (word) or high byte (byte)
    typedef enum logic [2:0] {
        FOP_NONE = 3'b000,
        FOP_LOAD = 3'b001,
        FOP_AND = 3'b010,
        FOP_OR = 3'b011,
        FOP_XOR = 3'b100,
        FOP_ALU = 3'b101
    } crf_flag_op_t;

    typedef enum logic [1:0] {
        AMODE_NORMAL = 2'b00,
        AMODE_1M = 2'b01,
        AMODE_ADV = 2'b10
    } crf_amode_t;

    typedef enum logic [1:0] {
        CST_RESET = 2'b00,
        CST_RUN = 2'b01
    } crf_state_t;
endpackage : crf_pkg

// File: rtl/crf_regmem.sv
`timescale 1ns/10ps
// eight-entry register store with byte lanes and registered reads
module crf_regmem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 32
) (
    input wire logic clk, // core clock
    input wire logic [2:0] wr_idx, // write entry
    input wire logic [3:0] wr_lane, // byte lane enables
    input wire logic [WIDTH-1:0] wr_data, // write data, lane aligned
    input wire logic [2:0] ra_idx, // read port a entry
    input wire logic [2:0] rb_idx, // read port b entry
    output logic [WIDTH-1:0] ra_data, // read port a data
    output logic [WIDTH-1:0] rb_data, // read port b data
    output logic [WIDTH-1:0] sp_data // last entry, always visible
);
    logic [WIDTH-1:0] mem [DEPTH];

    // ---------------------------------------------------------------
    // per-entry write, untouched lanes keep their value
    // ---------------------------------------------------------------
    genvar g;
    for (g = 0; g < DEPTH; g++) begin : g_entry
        wire hit = (wr_idx == 3'(g)); // this entry addressed
        always_ff @(posedge clk) begin
            for (int l = 0; l < 4; l++) begin
                if (hit && wr_lane[l]) begin
                    mem[g][l*8 +: 8] <= wr_data[l*8 +: 8]; // [RULE23]
                end
            end
        end
    end

    // registered reads; contents are undefined until written
    always_ff @(posedge clk) begin
        ra_data <= mem[ra_idx];
        rb_data <= mem[rb_idx];
        sp_data <= mem[DEPTH-1];
    end
endmodule : crf_regmem

// File: verification/crf_core_regs_bench.sv
`timescale 1ns/10ps
module crf_core_regs_bench;
    localparam logic [31:0] SP_INIT = 32'h00fffc00;
    localparam logic [23:0] VEC = 24'h12345b;
    logic CLOCK, RST_N, RD_EN, req, PTR_LOAD, PTR_STEP, ALU_SUB, ALU_ARITH, ALU_CIN, ALU_ZKEEP;
    logic CARRY_SET, CARRY_VAL, EXC_START, IRQ_REQ, NMI_REQ, WR_EN, IRQ_TAKE, BR_TAKEN;
    logic [1:0] AMODE, RD_SIZE, size, WR_SIZE, DATA_SIZE, ALU_SIZE;
    logic [2:0] FLAG_OP;
    logic [3:0] RA_SEL, RB_SEL, sel, WR_SEL, BR_COND;
    logic [7:0] FLAG_IMM, CONDITION_FLAGS;
    logic [23:0] PTR_VALUE, DATA_ADDR, FETCH_ADDR, BUS_ADDR;
    logic [31:0] data, WR_DATA, ALU_A, ALU_B, RA_DATA, RB_DATA, STACK_POINTER;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    crf_exec_model #(.SP_INIT(SP_INIT)) prog (.clk(CLOCK), .rst_n(RST_N), .req(req), .sel(sel), .size(size),
        .data(data), .wr_en(WR_EN), .wr_sel(WR_SEL), .wr_size(WR_SIZE), .wr_data(WR_DATA));
    crf_core_regs dut (.CLOCK, .RST_N, .AMODE, .RESET_VECTOR(VEC), .RD_EN, .RA_SEL, .RB_SEL, .RD_SIZE, .WR_EN,
        .WR_SEL, .WR_SIZE, .WR_DATA, .PTR_LOAD, .PTR_VALUE, .PTR_STEP, .DATA_ADDR, .DATA_SIZE, .FLAG_OP,
        .FLAG_IMM, .ALU_SIZE, .ALU_SUB, .ALU_ARITH, .ALU_A, .ALU_B, .ALU_CIN, .ALU_ZKEEP, .CARRY_SET,
        .CARRY_VAL, .EXC_START, .IRQ_REQ, .NMI_REQ, .BR_COND, .RA_DATA, .RB_DATA, .STACK_POINTER,
        .FETCH_ADDR, .BUS_ADDR, .CONDITION_FLAGS, .IRQ_TAKE, .BR_TAKEN);
    // clock and hang guard
    initial CLOCK = 1'b0;
    always #5 CLOCK = ~CLOCK;
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic tick(input int n);
        repeat (n) @(negedge CLOCK);
    endtask : tick
    // write request stays up until rd drops it
    task automatic wr(input logic [3:0] s, input logic [1:0] z, input logic [31:0] d);
        sel = s;
        size = z;
        data = d;
        req = 1'b1;
        tick(1);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [3:0] b, input logic [1:0] z);
        req = 1'b0;
        RA_SEL = a;
        RB_SEL = b;
        RD_SIZE = z;
        RD_EN = 1'b1;
        tick(1);
        RD_EN = 1'b0;
        tick(2);
    endtask : rd
    task automatic fop(input logic [2:0] op, input logic [7:0] imm);
        FLAG_OP = op;
        FLAG_IMM = imm;
        tick(1);
        FLAG_OP = 3'h0;
        tick(1);
    endtask : fop
    task automatic alu(input logic [1:0] z, input logic s, input logic [31:0] a, b, input logic [7:0] exp);
        ALU_SIZE = z;
        ALU_SUB = s;
        ALU_A = a;
        ALU_B = b;
        fop(3'h5, 8'h00);
        check(CONDITION_FLAGS, exp);
    endtask : alu
    task automatic t_regs();
        for (int i = 0; i < 8; i++) wr({1'b0, 3'(i)}, 2'h2, {4'(i), 28'h1234567});
        for (int i = 0; i < 8; i++) begin
            rd({1'b0, 3'(i)}, {1'b0, 3'(7 - i)}, 2'h2);
            check(RA_DATA, {4'(i), 28'h1234567});
            check(RB_DATA, {4'(7 - i), 28'h1234567});
        end
        check(STACK_POINTER, {4'h7, 28'h1234567});
        wr(4'hb, 2'h1, 32'h0000aaaa);
        wr(4'h3, 2'h0, 32'h00000055);
        wr(4'hb, 2'h0, 32'h00000066);
        rd(4'h3, 4'h3, 2'h2);
        check(RA_DATA, 32'haaaa6655);
        rd(4'hb, 4'h3, 2'h1);
        check(RA_DATA, 32'h0000aaaa);
        check(RB_DATA, 32'h00006655);
        rd(4'hb, 4'h3, 2'h0);
        check(RA_DATA, 32'h00000066);
        check(RB_DATA, 32'h00000055);
    endtask : t_regs
    task automatic t_flags();
        fop(3'h1, 8'h50);
        check(CONDITION_FLAGS, 8'h50);
        fop(3'h3, 8'h0f);
        check(CONDITION_FLAGS, 8'h5f);
        fop(3'h2, 8'hf3);
        check(CONDITION_FLAGS, 8'h53);
        fop(3'h4, 8'hff);
        check(CONDITION_FLAGS, 8'hac);
        fop(3'h1, 8'h00);
        EXC_START = 1'b1;
        FLAG_OP = 3'h1;
        tick(1);
        EXC_START = 1'b0;
        FLAG_OP = 3'h0;
        check(CONDITION_FLAGS, 8'h80);
        IRQ_REQ = 1'b1;
        tick(2);
        check(IRQ_TAKE, 1'b0);
        NMI_REQ = 1'b1;
        tick(1);
        NMI_REQ = 1'b0;
        check(IRQ_TAKE, 1'b1);
        fop(3'h1, 8'h00);
        check(IRQ_TAKE, 1'b1);
        IRQ_REQ = 1'b0;
        check(BR_TAKEN, 1'b1);
    endtask : t_flags
    task automatic t_alu();
        alu(2'h0, 1'b0, 32'h08, 32'h08, 8'h20);
        alu(2'h0, 1'b0, 32'h80, 32'h80, 8'h07);
        alu(2'h1, 1'b0, 32'h0800, 32'h0800, 8'h20);
        alu(2'h2, 1'b0, 32'h08000000, 32'h08000000, 8'h20);
        alu(2'h0, 1'b1, 32'h10, 32'h01, 8'h20);
        alu(2'h2, 1'b1, 32'h0, 32'h1, 8'h29);
        alu(2'h1, 1'b1, 32'h8000, 32'h1, 8'h22);
        ALU_CIN = 1'b1;
        alu(2'h0, 1'b0, 32'h07, 32'h08, 8'h20);
        ALU_ZKEEP = 1'b1;
        alu(2'h0, 1'b0, 32'hff, 32'h00, 8'h21);
        ALU_CIN = 1'b0;
        ALU_ZKEEP = 1'b0;
        CARRY_SET = 1'b1;
        tick(1);
        CARRY_SET = 1'b0;
        check(CONDITION_FLAGS, 8'h20);
        CARRY_VAL = 1'b1;
        CARRY_SET = 1'b1;
        tick(1);
        CARRY_SET = 1'b0;
        check(CONDITION_FLAGS, 8'h21);
        BR_COND = 4'h5;
        tick(1);
        check(BR_TAKEN, 1'b1);
        BR_COND = 4'h7;
        tick(1);
        check(BR_TAKEN, 1'b0);
    endtask : t_alu
    task automatic t_addr();
        logic [23:0] m;
        PTR_VALUE = 24'h800101;
        PTR_LOAD = 1'b1;
        tick(1);
        PTR_LOAD = 1'b0;
        PTR_STEP = 1'b1;
        tick(1);
        PTR_STEP = 1'b0;
        check(FETCH_ADDR, 24'h800100);
        tick(1);
        check(FETCH_ADDR, 24'h800102);
        DATA_ADDR = 24'habcdef;
        for (int md = 0; md < 3; md++) begin
            for (int z = 0; z < 2; z++) begin
                AMODE = 2'(md);
                DATA_SIZE = 2'(z);
                tick(1);
                m = (md == 0) ? crf_pkg::ADDR_64K_MASK : (md == 1) ? crf_pkg::ADDR_1M_MASK : 24'hffffff;
                check(BUS_ADDR, DATA_ADDR & m & {23'h7fffff, z == 0});
            end
        end
    endtask : t_addr
    // main sequence
    initial begin
        {RST_N, RD_EN, req, PTR_LOAD, PTR_STEP, ALU_SUB, ALU_CIN, ALU_ZKEEP, CARRY_SET, CARRY_VAL} = '0;
        {EXC_START, IRQ_REQ, NMI_REQ, FLAG_OP, FLAG_IMM, BR_COND, RD_SIZE, DATA_SIZE, ALU_SIZE} = '0;
        {RA_SEL, RB_SEL, sel, size, PTR_VALUE, DATA_ADDR, data, ALU_A, ALU_B} = '0;
        AMODE = 2'h2;
        ALU_ARITH = 1'b1;
        tick(2);
        check(CONDITION_FLAGS, 8'h80);
        RST_N = 1'b1;
        tick(4);
        check(FETCH_ADDR, 24'h12345a);
        check(STACK_POINTER, SP_INIT);
        t_regs();
        t_flags();
        t_alu();
        t_addr();
        tally_and_finish();
    end
endmodule : crf_core_regs_bench

// File: verification/crf_core_regs_properties.sv
`timescale 1ns/10ps
// ----------------------------------------
// flag, interrupt and address checks on the core ports
// ----------------------------------------
module crf_core_regs_properties (
    input wire logic CLOCK, // core clock
    input wire logic RST_N, // reset, active low
    input wire logic [1:0] DATA_SIZE, // data size
    input wire logic [2:0] FLAG_OP, // flag op
    input wire logic [7:0] FLAG_IMM, // flag immediate
    input wire logic [1:0] ALU_SIZE, // alu size
    input wire logic ALU_SUB, // subtract form
    input wire logic ALU_ARITH, // arithmetic flags
    input wire logic [31:0] ALU_A, // operand a
    input wire logic [31:0] ALU_B, // operand b
    input wire logic ALU_CIN, // carry in
    input wire logic ALU_ZKEEP, // zero keep
    input wire logic CARRY_SET, // carry override
    input wire logic EXC_START, // exception start
    input wire logic NMI_REQ, // nmi request
    input wire logic [23:0] FETCH_ADDR, // fetch address
    input wire logic [23:0] BUS_ADDR, // bus address
    input wire logic [7:0] CONDITION_FLAGS, // flags
    input wire logic IRQ_TAKE // irq accepted
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);
    logic [32:0] lo_m, sz_m, ea, eb, ci, res;
    logic hc, cy, go;
    // operands cut to the half-carry and result widths
    assign lo_m = (ALU_SIZE == 2'h0) ? 33'hf : (ALU_SIZE == 2'h1) ? 33'hfff : 33'hfffffff;
    assign sz_m = (ALU_SIZE == 2'h0) ? 33'hff : (ALU_SIZE == 2'h1) ? 33'hffff : 33'hffffffff;
    assign ea = {1'b0, ALU_A};
    assign eb = {1'b0, ALU_B};
    assign ci = {32'h0, ALU_CIN};
    assign hc = ALU_SUB ? (ea & lo_m) < (eb & lo_m) + ci : (ea & lo_m) + (eb & lo_m) + ci > lo_m;
    assign cy = ALU_SUB ? (ea & sz_m) < (eb & sz_m) + ci : (ea & sz_m) + (eb & sz_m) + ci > sz_m;
    assign res = ALU_SUB ? ea - eb - ci : ea + eb + ci;
    assign go = FLAG_OP == 3'h5 && ALU_ARITH && !ALU_ZKEEP && !CARRY_SET && !EXC_START;
    // one flag bit after a plain arithmetic step
    property p_alu(int b, logic e);
        go && $past(RST_N) |=> CONDITION_FLAGS[b] == $past(e);
    endproperty
    chk_half_carry: assert property (p_alu(5, hc)) else $error("half-carry flag wrong");
    chk_zero_flag: assert property (p_alu(2, (res & sz_m) == 33'h0)) else $error("zero flag wrong");
    chk_carry_flag: assert property (p_alu(0, cy)) else $error("carry flag wrong");
    chk_exc_mask: assert property (EXC_START |=> CONDITION_FLAGS[7]) else $error("mask not set");
    chk_nmi_take: assert property (NMI_REQ |=> IRQ_TAKE) else $error("nmi not taken");
    chk_irq_block: assert property (CONDITION_FLAGS[7] && !NMI_REQ |=> !IRQ_TAKE) else $error("irq leaked");
    chk_bus_even: assert property (DATA_SIZE != 2'h0 |=> !BUS_ADDR[0]) else $error("odd bus address");
    chk_fetch_even: assert property (FETCH_ADDR[0] == 1'b0) else $error("odd fetch address");
    chk_flag_load: assert property (FLAG_OP == 3'h1 && !EXC_START && !CARRY_SET && $past(RST_N)
        |=> CONDITION_FLAGS == $past(FLAG_IMM)) else $error("flag load wrong");
    cov_exc: cover property (EXC_START ##1 CONDITION_FLAGS[7]);
    cov_nmi: cover property (NMI_REQ ##1 IRQ_TAKE);
    cov_alu: cover property (go && hc);
endmodule : crf_core_regs_properties

bind crf_core_regs crf_core_regs_properties chk (.CLOCK, .RST_N, .DATA_SIZE, .FLAG_OP, .FLAG_IMM, .ALU_SIZE,
    .ALU_SUB, .ALU_ARITH, .ALU_A, .ALU_B, .ALU_CIN, .ALU_ZKEEP, .CARRY_SET, .EXC_START, .NMI_REQ,
    .FETCH_ADDR, .BUS_ADDR, .CONDITION_FLAGS, .IRQ_TAKE);

// File: verification/crf_exec_model.sv
`timescale 1ns/10ps
// -----------------------------------
// execution side: register write port
// -----------------------------------
module crf_exec_model #(
    parameter logic [31:0] SP_INIT = 32'h00fffc00
) (
    input wire logic clk, // core clock
    input wire logic rst_n, // reset, active low
    input wire logic req, // program write request
    input wire logic [3:0] sel, // view
    input wire logic [1:0] size, // size
    input wire logic [31:0] data, // data
    output logic wr_en, // to core
    output logic [3:0] wr_sel, // to core
    output logic [1:0] wr_size, // to core
    output logic [31:0] wr_data // to core
);
    logic [1:0] boot;
    // step 2 is the first request slot after reset; step 1 writes the stack pointer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot <= 2'h0;
        end else if (boot != 2'h2) begin
            boot <= boot + 2'h1;
        end
    end
    // stack pointer gets a longword move before anything else
    assign wr_en = (boot == 2'h1) | (req & boot == 2'h2);
    assign wr_sel = (boot == 2'h1) ? 4'h7 : sel;
    assign wr_size = (boot == 2'h1) ? 2'h2 : size;
    // idle data flips so a stale value never looks valid
    assign wr_data = (boot == 2'h1) ? SP_INIT : (req ? data : ~data);
endmodule : crf_exec_model
